// ===== logic/csdv_config_store.sv
// Nonvolatile parameter store objects: save, discard, marker and user memory.
// Assumes object dictionary accesses arrive as one-cycle strobes and that a
// separate controller performs the actual nonvolatile store and erase.
//
// Overview of operation
// - Discard signature in a discard subindex erases that category's stored copy.
// - Subindices 01h..06h select all, communication, application, customer, drive, tuning.
// - Discard through subindex 01h erases everything except tuning.
// - Tuning storage is erased only through discard subindex 06h.
// - After the erase completes the device requests its own restart.
// - Marker date and time are writable and stored with a save of all.
// - Category saves and savable writes to other objects clear both markers; save-all does not.
// - Eight 16-bit user words sit in subindices 02..09 of user memory.
// - Writing one to user subindex 01 saves the words; reads zero when done.
// - Save signature stores the category; the subindex then reads one.
module csdv_config_store
  import csdv_pkg::*;
(
  // Clock and reset.
  input  wire logic                         CLOCK,
  input  wire logic                         SYS_RST,
  // Object dictionary access.
  input  wire logic                         OD_WR,
  input  wire logic                         OD_RD,
  input  wire logic [15:0]                  OD_INDEX,
  input  wire logic [7:0]                   OD_SUBIDX,
  input  wire logic [31:0]                  OD_WDATA,
  input  wire logic                         OD_WR_SAVABLE,
  output logic                              OD_ACK,
  output logic                              OD_ABORT,
  output logic [31:0]                       OD_RDATA,
  // Boot restore of stored values.
  input  wire logic                         LOAD_WE,
  input  wire logic [15:0]                  LOAD_INDEX,
  input  wire logic [7:0]                   LOAD_SUBIDX,
  input  wire logic [31:0]                  LOAD_DATA,
  // Nonvolatile controller.
  output logic                              NV_REQ,
  output csdv_op_t                          NV_OP,
  output logic [CAT_W-1:0]                  NV_CAT_MASK,
  input  wire logic                         NV_ACK,
  output logic [31:0]                       MARKER_DATE,
  output logic [31:0]                       MARKER_TIME,
  output logic [USER_WORDS*USER_W-1:0]      USER_DATA,
  // Status.
  output logic                              STORE_BUSY,
  output logic                              RESTART_REQ
);

  // Hit decoding of the addressed object.
  wire hit_save    = (OD_INDEX == IDX_SAVE);
  wire hit_discard = (OD_INDEX == IDX_DISCARD);
  wire hit_marker  = (OD_INDEX == IDX_MARKER);
  wire hit_user    = (OD_INDEX == IDX_USER);
  wire hit_any     = hit_save | hit_discard | hit_marker | hit_user;

  // Subindex classes.
  wire sub_zero  = (OD_SUBIDX == SUB_COUNT);
  wire sub_cat   = sub_in(OD_SUBIDX, SUB_ALL, SUB_TUNE);
  wire sub_mark  = (OD_SUBIDX == SUB_DATE) | (OD_SUBIDX == SUB_TIME);
  wire sub_utrig = (OD_SUBIDX == SUB_UTRIG);
  wire sub_uword = sub_in(OD_SUBIDX, SUB_UFIRST, SUB_ULAST);

  // Sequencer and halt state.
  logic             seq_busy;
  logic             seq_done;
  csdv_op_t         seq_op_q;
  logic [CAT_W-1:0] seq_mask_q;
  logic             halted_q;
  logic [7:0]       pend_sub_q;
  wire              blocked = seq_busy | halted_q;

  // Accepted writes; anything else to our objects is refused.
  wire wr_save_ok    = OD_WR & hit_save & sub_cat & ~blocked
                       & (OD_WDATA == SIG_SAVE);
  wire wr_discard_ok = OD_WR & hit_discard & sub_cat & ~blocked
                       & (OD_WDATA == SIG_DISCARD);
  wire wr_marker_ok  = OD_WR & hit_marker & sub_mark & ~halted_q;
  wire wr_utrig_ok   = OD_WR & hit_user & sub_utrig & ~blocked
                       & (OD_WDATA == UTRIG_START);
  wire wr_uword_ok   = OD_WR & hit_user & sub_uword & ~blocked;
  wire wr_ok         = wr_save_ok | wr_discard_ok | wr_marker_ok
                       | wr_utrig_ok | wr_uword_ok;

  // Marker clearing: category saves and foreign savable objects, not save-all.
  wire clr_by_save    = OD_WR & hit_save & sub_cat & (OD_SUBIDX != SUB_ALL);
  wire clr_by_foreign = OD_WR & OD_WR_SAVABLE & ~hit_any;
  wire marker_clr     = clr_by_save | clr_by_foreign;

  // Category masks for the two kinds of operation.
  wire [CAT_W-1:0] save_mask    = cat_mask(OD_SUBIDX, MASK_ALL_SAVE);
  wire [CAT_W-1:0] discard_mask = cat_mask(OD_SUBIDX,
                                           MASK_ALL_DISCARD);

  // Start request to the sequencer.
  wire              seq_start = wr_save_ok | wr_discard_ok | wr_utrig_ok;
  wire csdv_op_t    seq_op    = wr_discard_ok ? CSDV_OP_ERASE :
                                wr_utrig_ok   ? CSDV_OP_USER  : CSDV_OP_SAVE;
  wire [CAT_W-1:0]  seq_mask  = wr_discard_ok ? discard_mask :
                                wr_save_ok    ? save_mask    : '0;

  // Completion events.
  wire save_done  = seq_done & (seq_op_q == CSDV_OP_SAVE);
  wire erase_done = seq_done & (seq_op_q == CSDV_OP_ERASE);
  wire user_done  = seq_done & (seq_op_q == CSDV_OP_USER);

  csdv_nv_seq u_seq (
    .clk    (CLOCK),
    .rst    (SYS_RST),
    .start  (seq_start),
    .op     (seq_op),
    .mask   (seq_mask),
    .busy   (seq_busy),
    .done   (seq_done),
    .op_q   (seq_op_q),
    .mask_q (seq_mask_q),
    .nv_req (NV_REQ),
    .nv_ack (NV_ACK)
  );

  // Boot restore decoding.
  wire load_date  = LOAD_WE & (LOAD_INDEX == IDX_MARKER) & (LOAD_SUBIDX == SUB_DATE);
  wire load_time  = LOAD_WE & (LOAD_INDEX == IDX_MARKER) & (LOAD_SUBIDX == SUB_TIME);
  wire load_uword = LOAD_WE & (LOAD_INDEX == IDX_USER)
                    & sub_in(LOAD_SUBIDX, SUB_UFIRST, SUB_ULAST);

  // User memory write mux; the boot restore has priority.
  wire                  um_we    = wr_uword_ok | load_uword;
  wire [USER_IDX_W-1:0] um_widx  = load_uword ? word_idx(LOAD_SUBIDX) : word_idx(OD_SUBIDX);
  wire [USER_W-1:0]     um_wdata = load_uword ? LOAD_DATA[USER_W-1:0] : OD_WDATA[USER_W-1:0];
  logic [USER_W-1:0]    um_rdata;

  csdv_user_mem #(
    .WORDS (USER_WORDS),
    .WIDTH (USER_W)
  ) u_umem (
    .clk   (CLOCK),
    .rst   (SYS_RST),
    .we    (um_we),
    .widx  (um_widx),
    .wdata (um_wdata),
    .ridx  (word_idx(OD_SUBIDX)),
    .rdata (um_rdata),
    .flat  (USER_DATA)
  );

  // Marker registers.
  logic [31:0] date_q;
  logic [31:0] time_q;
  logic [31:0] date_d;
  logic [31:0] time_d;

  // Marker next values; a write or restore in the same cycle beats a clear.
  always_comb begin
    date_d = date_q;
    time_d = time_q;
    if (marker_clr) begin
      date_d = MARKER_RESET;
      time_d = MARKER_RESET;
    end
    if (wr_marker_ok & (OD_SUBIDX == SUB_DATE)) begin
      date_d = OD_WDATA;
    end
    if (wr_marker_ok & (OD_SUBIDX == SUB_TIME)) begin
      time_d = OD_WDATA;
    end
    if (load_date) begin
      date_d = LOAD_DATA;
    end
    if (load_time) begin
      time_d = LOAD_DATA;
    end
  end

  // Markers reset to zero until restored.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      date_q <= MARKER_RESET;
      time_q <= MARKER_RESET;
    end else begin
      date_q <= date_d;
      time_q <= time_d;
    end
  end

  // User trigger: one from start until the store finishes.
  logic utrig_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      utrig_q <= 1'b0;
    end else if (wr_utrig_ok) begin
      utrig_q <= 1'b1;
    end else if (user_done) begin
      utrig_q <= 1'b0;
    end
  end

  // Save subindex in flight, shown as the signature until done.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pend_sub_q <= SUB_COUNT;
    end else if (wr_save_ok) begin
      pend_sub_q <= OD_SUBIDX;
    end else if (save_done) begin
      pend_sub_q <= SUB_COUNT;
    end
  end

  // Restart once the erase has completed; further writes are then refused.
  logic restart_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      restart_q <= 1'b0;
      halted_q  <= 1'b0;
    end else begin
      restart_q <= erase_done;
      if (erase_done) begin
        halted_q <= 1'b1;
      end
    end
  end

  // Read value selection.
  wire        save_pend_hit = (pend_sub_q == OD_SUBIDX) & (pend_sub_q != SUB_COUNT);
  wire [31:0] save_rd       = sub_zero      ? SAVE_ENTRIES :
                              save_pend_hit ? SIG_SAVE     : SAVE_DONE_VAL;
  wire [31:0] marker_rd     = sub_zero ? MARKER_ENTRIES :
                              (OD_SUBIDX == SUB_DATE) ? date_q : time_q;
  wire [31:0] user_rd       = sub_zero  ? USER_ENTRIES :
                              sub_utrig ? {31'h00000000, utrig_q} :
                              {16'h0000, um_rdata};
  wire [31:0] rd_val        = hit_save   ? save_rd   :
                              hit_marker ? marker_rd :
                              hit_user   ? user_rd   :
                              (hit_discard & sub_zero) ? SAVE_ENTRIES : 32'h00000000;

  // Read legality; discard entries other than the count are write-only.
  wire rd_ok = (hit_save & (sub_zero | sub_cat))
               | (hit_discard & sub_zero)
               | (hit_marker & (sub_zero | sub_mark))
               | (hit_user & (sub_zero | sub_utrig | sub_uword));

  // Answer one cycle after any access to one of our objects.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      OD_ACK   <= 1'b0;
      OD_ABORT <= 1'b0;
      OD_RDATA <= 32'h00000000;
    end else begin
      OD_ACK   <= (OD_WR | OD_RD) & hit_any;
      OD_ABORT <= (OD_WR & hit_any & ~wr_ok) | (OD_RD & hit_any & ~rd_ok);
      if (OD_RD & hit_any) begin
        OD_RDATA <= rd_ok ? rd_val : 32'h00000000;
      end
    end
  end

  // Outputs toward the controller and status.
  assign NV_OP       = seq_op_q;
  assign NV_CAT_MASK = seq_mask_q;
  assign MARKER_DATE = date_q;
  assign MARKER_TIME = time_q;
  assign STORE_BUSY  = seq_busy;
  assign RESTART_REQ = restart_q;

endmodule

// ===== logic/csdv_pkg.sv
// Shared constants, types and helpers for the configuration store block.
// Assumes one clock domain and an object dictionary access port that presents
// index, subindex and data with one-cycle read and write strobes.
package csdv_pkg;

  // Object indices handled by this block.
  localparam logic [15:0] IDX_SAVE    = 16'h1010;
  localparam logic [15:0] IDX_DISCARD = 16'h1011;
  localparam logic [15:0] IDX_MARKER  = 16'h1020;
  localparam logic [15:0] IDX_USER    = 16'h2700;

  // Signatures that arm a store or a discard.
  localparam logic [31:0] SIG_SAVE    = 32'h65766173;
  localparam logic [31:0] SIG_DISCARD = 32'h64616F6C;

  // Subindices shared by the save and discard objects.
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_ALL   = 8'h01;
  localparam logic [7:0] SUB_COMM  = 8'h02;
  localparam logic [7:0] SUB_APP   = 8'h03;
  localparam logic [7:0] SUB_CUST  = 8'h04;
  localparam logic [7:0] SUB_DRIVE = 8'h05;
  localparam logic [7:0] SUB_TUNE  = 8'h06;

  // Subindices of the marker and user memory objects.
  localparam logic [7:0] SUB_DATE   = 8'h01;
  localparam logic [7:0] SUB_TIME   = 8'h02;
  localparam logic [7:0] SUB_UTRIG  = 8'h01;
  localparam logic [7:0] SUB_UFIRST = 8'h02;
  localparam logic [7:0] SUB_ULAST  = 8'h09;

  // Entry counts reported in subindex zero.
  localparam logic [31:0] SAVE_ENTRIES   = 32'h00000006;
  localparam logic [31:0] MARKER_ENTRIES = 32'h00000002;
  localparam logic [31:0] USER_ENTRIES   = 32'h00000009;

  // Category mask: bit 0 communication up to bit 4 tuning.
  localparam int            CAT_W            = 5;
  localparam logic [CAT_W-1:0] MASK_ALL_SAVE    = 5'h1F;
  localparam logic [CAT_W-1:0] MASK_ALL_DISCARD = 5'h0F;

  // Values shown by the save subindices, the user trigger and the cleared markers.
  localparam logic [31:0] SAVE_DONE_VAL = 32'h00000001;
  localparam logic [31:0] UTRIG_START   = 32'h00000001;
  localparam logic [31:0] MARKER_RESET  = 32'h00000000;

  // User memory geometry.
  localparam int USER_WORDS = 8;
  localparam int USER_W     = 16;
  localparam int USER_IDX_W = 3;

  // Operations handed to the nonvolatile controller.
  typedef enum logic [1:0] {
    CSDV_OP_SAVE,
    CSDV_OP_ERASE,
    CSDV_OP_USER
  } csdv_op_t;

  // True when a subindex lies within an inclusive range.
  function automatic logic sub_in(input logic [7:0] sub, input logic [7:0] lo,
                                  input logic [7:0] hi);
    return (sub >= lo) && (sub <= hi);
  endfunction

  // Category mask selected by a save or discard subindex.
  function automatic logic [CAT_W-1:0] cat_mask(input logic [7:0] sub,
                                                input logic [CAT_W-1:0] all_mask);
    logic [7:0] sh;
    sh = sub - SUB_COMM;
    if (sub == SUB_ALL) begin
      return all_mask;
    end else if (sub_in(sub, SUB_COMM, SUB_TUNE)) begin
      return CAT_W'(1) << sh[2:0];
    end else begin
      return '0;
    end
  endfunction

  // Word index of a user memory subindex.
  function automatic logic [USER_IDX_W-1:0] word_idx(input logic [7:0] sub);
    logic [7:0] d;
    d = sub - SUB_UFIRST;
    return d[USER_IDX_W-1:0];
  endfunction

endpackage

// ===== logic/csdv_nv_seq.sv
// Handshake with the external nonvolatile controller, one operation at a time.
// Assumes the controller answers a held request with a one-cycle acknowledge
// on the same clock.
module csdv_nv_seq
  import csdv_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Start of an operation.
  input  wire logic             start,
  input  wire csdv_op_t         op,
  input  wire logic [CAT_W-1:0] mask,
  // Progress.
  output logic                  busy,
  output logic                  done,
  output csdv_op_t              op_q,
  output logic [CAT_W-1:0]      mask_q,
  // Controller side.
  output logic                  nv_req,
  input  wire logic             nv_ack
);

  typedef enum logic {CSDV_SEQ_IDLE, CSDV_SEQ_WAIT} csdv_seq_t;

  csdv_seq_t state_q;
  logic      done_q;

  // Latch the operation, hold the request until the acknowledge arrives.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= CSDV_SEQ_IDLE;
      op_q    <= CSDV_OP_SAVE;
      mask_q  <= '0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      unique case (state_q)
        CSDV_SEQ_IDLE: begin
          if (start) begin
            state_q <= CSDV_SEQ_WAIT;
            op_q    <= op;
            mask_q  <= mask;
          end
        end
        CSDV_SEQ_WAIT: begin
          if (nv_ack) begin
            state_q <= CSDV_SEQ_IDLE;
            done_q  <= 1'b1;
          end
        end
      endcase
    end
  end

  // Request is a level for the whole wait.
  assign busy   = (state_q == CSDV_SEQ_WAIT);
  assign nv_req = busy;
  assign done   = done_q;

endmodule

// ===== logic/csdv_user_mem.sv
// Array of user words with one write port and one combinational read port.
// Assumes the caller has already checked the index range.
module csdv_user_mem
  import csdv_pkg::*;
#(
  parameter int WORDS = USER_WORDS,
  parameter int WIDTH = USER_W
) (
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Write port.
  input  wire logic                  we,
  input  wire logic [USER_IDX_W-1:0] widx,
  input  wire logic [WIDTH-1:0]      wdata,
  // Read port.
  input  wire logic [USER_IDX_W-1:0] ridx,
  output logic [WIDTH-1:0]           rdata,
  // All words side by side, word 0 in the low bits.
  output logic [WORDS*WIDTH-1:0]     flat
);

  logic [WIDTH-1:0] words_q [WORDS];

  // Words clear at reset until the boot restore fills them.
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int i = 0; i < WORDS; i++) begin
        words_q[i] <= '0;
      end
    end else if (we) begin
      words_q[widx] <= wdata;
    end
  end

  // Read and flatten the array.
  assign rdata = words_q[ridx];
  for (genvar g = 0; g < WORDS; g++) begin : g_flat
    assign flat[g*WIDTH +: WIDTH] = words_q[g];
  end

endmodule

// ===== tb/csdv_nv_model.sv
// Behavioural nonvolatile controller that answers store and erase requests.
// Assumes the request is held until the one-cycle acknowledge.
module csdv_nv_model (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Request side.
  input  wire logic req,
  input  wire logic slow,
  output logic      ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt;
  // Counts a held request and answers after a short or a long store time.
  always_ff @(posedge clk) begin
    if (rst || !req || ack) begin
      cnt <= 32'h0;
      ack <= 1'b0;
    end else begin
      cnt <= cnt + 32'h1;
      ack <= (cnt == (slow ? 32'h14 : 32'h1));
    end
  end
endmodule

// ===== tb/csdv_config_store_chk.sv
// Checker for the configuration store ports.
// Assumes one clock and a synchronous active-high reset.
module csdv_chk
  import csdv_pkg::*;
(
  // Clock and reset.
  input wire logic             CLOCK,
  input wire logic             SYS_RST,
  // Object access.
  input wire logic             OD_WR,
  input wire logic [15:0]      OD_INDEX,
  input wire logic [7:0]       OD_SUBIDX,
  input wire logic [31:0]      OD_WDATA,
  input wire logic             OD_WR_SAVABLE,
  input wire logic             OD_ACK,
  input wire logic             OD_ABORT,
  input wire logic             LOAD_WE,
  // Controller side and status.
  input wire logic             NV_REQ,
  input wire csdv_op_t         NV_OP,
  input wire logic [CAT_W-1:0] NV_CAT_MASK,
  input wire logic             NV_ACK,
  input wire logic [31:0]      MARKER_DATE,
  input wire logic [31:0]      MARKER_TIME,
  input wire logic             STORE_BUSY,
  input wire logic             RESTART_REQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // Remembers a restart request, after which writes are refused.
  logic rs_q;
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      rs_q <= 1'b0;
    end else if (RESTART_REQ) begin
      rs_q <= 1'b1;
    end
  end
  // Access decoding shared by the properties.
  wire own = (OD_INDEX == IDX_SAVE) || (OD_INDEX == IDX_DISCARD) ||
             (OD_INDEX == IDX_MARKER) || (OD_INDEX == IDX_USER);
  wire live = !rs_q && !RESTART_REQ && !LOAD_WE && !STORE_BUSY;
  wire dis_wr = OD_WR && (OD_INDEX == IDX_DISCARD) && (OD_SUBIDX >= SUB_ALL) &&
                (OD_SUBIDX <= SUB_TUNE);
  wire sav_wr = OD_WR && (OD_INDEX == IDX_SAVE) && (OD_SUBIDX == SUB_ALL);
  property p_dis_bad;
    dis_wr && (OD_WDATA != SIG_DISCARD) |=> OD_ACK && OD_ABORT;
  endproperty
  a_dis_bad: assert property (p_dis_bad) else $error("wrong discard value taken");
  property p_dis_mask;
    dis_wr && (OD_WDATA == SIG_DISCARD) && live |=> NV_REQ && (NV_OP == CSDV_OP_ERASE) &&
      (NV_CAT_MASK == (($past(OD_SUBIDX) == SUB_ALL) ? MASK_ALL_DISCARD :
                       5'h01 << ($past(OD_SUBIDX) - 8'h02)));
  endproperty
  a_dis_mask: assert property (p_dis_mask) else $error("wrong mask");
  property p_restart;
    NV_REQ && (NV_OP == CSDV_OP_ERASE) && NV_ACK |-> ##2 RESTART_REQ;
  endproperty
  a_restart: assert property (p_restart) else $error("no restart after erase");
  property p_mk_clr;
    OD_WR && OD_WR_SAVABLE && !own && !LOAD_WE |=> (MARKER_DATE == MARKER_RESET) &&
      (MARKER_TIME == MARKER_RESET);
  endproperty
  a_mk_clr: assert property (p_mk_clr) else $error("markers not cleared");
  property p_mk_keep;
    sav_wr && !LOAD_WE |=> $stable(MARKER_DATE) && $stable(MARKER_TIME);
  endproperty
  a_mk_keep: assert property (p_mk_keep) else $error("save all changed markers");
  property p_mk_wr;
    OD_WR && (OD_INDEX == IDX_MARKER) && (OD_SUBIDX == SUB_DATE) && live |=>
      MARKER_DATE == $past(OD_WDATA);
  endproperty
  a_mk_wr: assert property (p_mk_wr) else $error("marker date not written");
  property p_save_all;
    sav_wr && (OD_WDATA == SIG_SAVE) && live |=> NV_REQ && (NV_OP == CSDV_OP_SAVE) &&
      (NV_CAT_MASK == MASK_ALL_SAVE);
  endproperty
  a_save_all: assert property (p_save_all) else $error("save all not started");
  property p_user_go;
    OD_WR && (OD_INDEX == IDX_USER) && (OD_SUBIDX == SUB_UTRIG) &&
      (OD_WDATA == UTRIG_START) && live |=> NV_REQ && (NV_OP == CSDV_OP_USER) ##1
      (NV_REQ || $past(NV_ACK));
  endproperty
  a_user_go: assert property (p_user_go) else $error("user save not started");
endmodule

bind csdv_config_store csdv_chk u_chk (
  .CLOCK, .SYS_RST, .OD_WR, .OD_INDEX, .OD_SUBIDX, .OD_WDATA, .OD_WR_SAVABLE, .OD_ACK,
  .OD_ABORT, .LOAD_WE, .NV_REQ, .NV_OP, .NV_CAT_MASK, .NV_ACK, .MARKER_DATE, .MARKER_TIME,
  .STORE_BUSY, .RESTART_REQ
);

// ===== tb/tb.sv
// Self-checking bench for the configuration store objects.
// Assumes the package constants and the behavioural store controller.
module tb
  import csdv_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic                       clk = 1'b0;
  logic                       rst = 1'b1;
  logic                       od_wr = 1'b0;
  logic                       od_rd = 1'b0;
  logic                       od_sav = 1'b0;
  logic                       ld_we = 1'b0;
  logic                       slow = 1'b0;
  logic [15:0]                od_idx = 16'h0;
  logic [7:0]                 od_sub = 8'h0;
  logic [31:0]                od_wd = 32'h0;
  logic [31:0]                ld_dat = 32'h0;
  logic [15:0]                ld_idx = IDX_MARKER;
  logic [7:0]                 ld_sub = SUB_TIME;
  logic                       ack, abt, nv_req, nv_ack, busy, restart;
  logic [31:0]                rdata, date, mtime;
  logic [CAT_W-1:0]           mask;
  logic [USER_WORDS*USER_W-1:0] udata;
  csdv_op_t                   nv_op;
  int                         fail_count = 0;
  int                         compares = 0;
  int                         cyc = 0;
  int                         rs_cnt = 0;

  csdv_config_store uut (
    .CLOCK(clk), .SYS_RST(rst), .OD_WR(od_wr), .OD_RD(od_rd), .OD_INDEX(od_idx),
    .OD_SUBIDX(od_sub), .OD_WDATA(od_wd), .OD_WR_SAVABLE(od_sav), .OD_ACK(ack),
    .OD_ABORT(abt), .OD_RDATA(rdata), .LOAD_WE(ld_we), .LOAD_INDEX(ld_idx),
    .LOAD_SUBIDX(ld_sub), .LOAD_DATA(ld_dat), .NV_REQ(nv_req), .NV_OP(nv_op),
    .NV_CAT_MASK(mask), .NV_ACK(nv_ack), .MARKER_DATE(date), .MARKER_TIME(mtime),
    .USER_DATA(udata), .STORE_BUSY(busy), .RESTART_REQ(restart)
  );
  csdv_nv_model nv (.clk(clk), .rst(rst), .req(nv_req), .slow(slow), .ack(nv_ack));

  // Clock of 10 ns period.
  always #5 clk = ~clk;

  // Counts restart pulses and cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (restart === 1'b1) begin
      rs_cnt++;
    end
    if (cyc == 20000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // Compares one value and reports a difference at once.
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    compares++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, x);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Holds reset for six cycles, released at a falling edge.
  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge clk);
    rst = 1'b0;
  endtask

  // One object access; the answer is taken one cycle after the strobe.
  task automatic acc(input logic w, input logic [15:0] i, input logic [7:0] s,
                     input logic [31:0] d, output logic [1:0] a, output logic [31:0] r);
    od_wr = w;
    od_rd = !w;
    od_idx = i;
    od_sub = s;
    od_wd = d;
    @(negedge clk);
    od_wr = 1'b0;
    od_rd = 1'b0;
    a = {ack, abt};
    r = rdata;
    @(negedge clk);
  endtask

  // Write expecting an answer, refused when e is high.
  task automatic wr(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                    input logic e);
    logic [1:0]  a;
    logic [31:0] r;
    acc(1'b1, i, s, d, a, r);
    chk(a, {1'b1, e});
  endtask

  // Read expecting an accepted answer carrying x.
  task automatic rd(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
    logic [1:0]  a;
    logic [31:0] r;
    acc(1'b0, i, s, 32'h0, a, r);
    chk(a, 2'b10);
    chk(r, x);
  endtask

  // Waits for the store to finish, then one more cycle.
  task automatic wait_idle();
    for (int n = 0; n < 200 && busy !== 1'b0; n++) begin
      @(negedge clk);
    end
    chk(busy, 1'b0);
    @(negedge clk);
  endtask

  // Main sequence.
  initial begin
    logic [1:0]  a;
    logic [31:0] r;
    int          n0;
    do_reset();
    rd(IDX_SAVE, SUB_COUNT, SAVE_ENTRIES);
    rd(IDX_DISCARD, SUB_COUNT, SAVE_ENTRIES);
    rd(IDX_MARKER, SUB_COUNT, MARKER_ENTRIES);
    rd(IDX_USER, SUB_COUNT, USER_ENTRIES);
    rd(IDX_USER, SUB_UTRIG, 32'h0);
    rd(IDX_SAVE, SUB_TUNE, SAVE_DONE_VAL);
    // Markers survive a save of all categories and are stored with it.
    wr(IDX_MARKER, SUB_DATE, 32'h07E80315, 1'b0);
    wr(IDX_MARKER, SUB_TIME, 32'h00123456, 1'b0);
    wr(IDX_SAVE, SUB_ALL, SIG_SAVE, 1'b0);
    chk(mask, MASK_ALL_SAVE);
    chk(nv_op, CSDV_OP_SAVE);
    rd(IDX_SAVE, SUB_ALL, SIG_SAVE);
    wait_idle();
    rd(IDX_SAVE, SUB_ALL, SAVE_DONE_VAL);
    chk(date, 32'h07E80315);
    chk(mtime, 32'h00123456);
    // A wrong discard value changes nothing.
    wr(IDX_DISCARD, SUB_APP, SIG_SAVE, 1'b1);
    chk(busy, 1'b0);
    // A savable foreign write gets no answer and clears the markers.
    od_sav = 1'b1;
    acc(1'b1, 16'h6040, 8'h00, 32'h0000000F, a, r);
    od_sav = 1'b0;
    chk(a, 2'b00);
    chk(date, MARKER_RESET);
    chk(mtime, MARKER_RESET);
    // Each category save clears the markers and ends reading one.
    for (int s = 2; s <= 6; s++) begin
      wr(IDX_MARKER, SUB_DATE, 32'h07E80315, 1'b0);
      wr(IDX_SAVE, 8'(s), SIG_SAVE, 1'b0);
      chk(mask, 32'h1 << (s - 2));
      chk(date, MARKER_RESET);
      wait_idle();
      rd(IDX_SAVE, 8'(s), SAVE_DONE_VAL);
    end
    // Boot restore of the marker time.
    ld_we = 1'b1;
    ld_dat = 32'hCAFE0001;
    @(negedge clk);
    ld_we = 1'b0;
    chk(mtime, 32'hCAFE0001);
    // User words, with the upper half of the write data ignored.
    for (int s = 2; s <= 9; s++) begin
      wr(IDX_USER, 8'(s), {16'hFFFF, 16'h1100 + 16'(s)}, 1'b0);
    end
    for (int s = 2; s <= 9; s++) begin
      rd(IDX_USER, 8'(s), 32'h1100 + 32'(s));
      chk(udata[(s - 2) * 16 +: 16], 32'h1100 + 32'(s));
    end
    // Boot restore of the last user word.
    ld_idx = IDX_USER;
    ld_sub = SUB_ULAST;
    ld_dat = 32'h0000BEEF;
    ld_we = 1'b1;
    @(negedge clk);
    ld_we = 1'b0;
    rd(IDX_USER, SUB_ULAST, 32'h0000BEEF);
    slow = 1'b1;
    wr(IDX_USER, SUB_UTRIG, 32'h2, 1'b1);
    wr(IDX_USER, SUB_UTRIG, UTRIG_START, 1'b0);
    chk(nv_op, CSDV_OP_USER);
    rd(IDX_USER, SUB_UTRIG, UTRIG_START);
    wr(IDX_USER, SUB_UFIRST, 32'h0, 1'b1);
    r = UTRIG_START;
    for (int n = 0; n < 100 && r !== 32'h0; n++) begin
      acc(1'b0, IDX_USER, SUB_UTRIG, 32'h0, a, r);
    end
    chk(r, 32'h0);
    chk(udata[15:0], 32'h1102);
    slow = 1'b0;
    chk(rs_cnt, 32'h0);
    // Every discard category erases and restarts on its own.
    for (int s = 1; s <= 6; s++) begin
      do_reset();
      rd(IDX_MARKER, SUB_DATE, MARKER_RESET);
      n0 = rs_cnt;
      wr(IDX_DISCARD, 8'(s), SIG_DISCARD, 1'b0);
      chk(nv_op, CSDV_OP_ERASE);
      chk(mask, (s == 1) ? 32'(MASK_ALL_DISCARD) : 32'h1 << (s - 2));
      for (int n = 0; n < 50 && rs_cnt == n0; n++) begin
        @(negedge clk);
      end
      chk(rs_cnt, n0 + 1);
      wr(IDX_MARKER, SUB_DATE, 32'h1, 1'b1);
    end
    chk(rs_cnt, 32'h6);
    tally_and_finish();
  end
endmodule
